// ===== apc_port.sv
// Purpose: Asynchronous peripheral configuration port of a programmable logic device.
// Assumes: Host strobes are asynchronous and held for at least three clock periods.
// Notes:   In user mode the pins are handed to the fabric untouched.
//
// What this block does
// - In peripheral mode, selected only while the low-active select is low and high-active select is high.
// - While selected and ready, a falling write strobe captures the eight data inputs into the buffer.
// - While selected with read strobe low, the top data line shows ready high, busy low.
// - During a status read the seven lower data lines are driven high.
// - If both strobes are low, the write wins and no status is driven.
// - In chain mode the high-active select acts as serial enable for accepting data.
// - After configuration the select and strobe pins become ordinary user pins.
// - In chain mode a status output drives the next device's high-active select.
`timescale 1ns/1ps
module apc_port
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire apc_pkg::apc_mode_t mode,
    input  wire logic              select_low_active_n,
    input  wire logic              select_high_active,
    input  wire logic              write_strobe_n,
    input  wire logic              read_strobe_n,
    input  wire logic [7:0]        config_byte_bus_in,
    output logic [7:0]             config_byte_bus_out,
    output logic [7:0]             config_byte_bus_oe,
    input  wire logic [7:0]        user_out,
    input  wire logic [7:0]        user_oe,
    output logic [3:0]             user_ctrl_pins,
    output logic [7:0]             user_data_pins,
    input  wire logic              core_ready,
    output logic [7:0]             cfg_byte,
    output logic                   cfg_byte_valid,
    output logic                   next_select_high,
    output logic                   ready_busy_flag
);

    apc_pkg::apc_pins_t     pins_raw;
    apc_pkg::apc_pins_t     pins;
    apc_pkg::apc_state_t    state_q;
    apc_pkg::apc_state_t    state_d;
    apc_pkg::apc_bus_drive_t drive;
    logic [7:0]             buffer_q;
    logic [7:0]             cnt_q;
    logic                   valid_q;
    logic                   wr_prev_q;
    logic [7:0]             cnt_d;

    // Everything below reads synchronised pins, so decisions lag the pins by two edges.
    wire config_mode = (mode != apc_pkg::APC_MODE_USER);
    wire chain_mode  = (mode == apc_pkg::APC_MODE_CHAIN);
    // Chain mode gates on the serial enable alone; peripheral mode needs both selects.
    wire selected    = config_mode && (chain_mode ? pins.sel : (!pins.sel_n && pins.sel));
    wire wr_active   = selected && !pins.wr_n;
    wire rd_active   = selected && !pins.rd_n && pins.wr_n;
    wire wr_fall     = wr_active && wr_prev_q;
    wire is_ready    = (state_q == apc_pkg::APC_ST_READY);
    wire cnt_done    = (cnt_q == apc_pkg::XFER_CNT_MAX);
    // Named decodes for the sequencer and the checks below.
    wire in_xfer     = (state_q == apc_pkg::APC_ST_XFER);
    wire load_byte   = wr_fall && is_ready;
    wire xfer_end    = in_xfer && (state_d == apc_pkg::APC_ST_READY);

    // The counter sits at its start value outside a transfer and parks at its end value.
    assign cnt_d = in_xfer ? (cnt_done ? cnt_q : cnt_q + 8'h01) : apc_pkg::CNT_RESET;

    assign pins_raw = '{sel_n: select_low_active_n, sel: select_high_active,
                        wr_n: write_strobe_n, rd_n: read_strobe_n, data: config_byte_bus_in};

    // The data pins share the strobes' synchroniser, so a byte and its strobe arrive together.
    apc_sync u_sync
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .pins_raw  (pins_raw),
        .pins_sync (pins)
    );

    // Only a fresh falling write is taken, so a long strobe loads one byte.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            apc_pkg::APC_ST_READY: if (wr_fall) state_d = apc_pkg::APC_ST_WAIT;
            apc_pkg::APC_ST_WAIT:  if (pins.wr_n || !selected) state_d = apc_pkg::APC_ST_XFER;
            apc_pkg::APC_ST_XFER:  if (cnt_done && core_ready) state_d = apc_pkg::APC_ST_READY;
            default:               state_d = apc_pkg::APC_ST_READY;
        endcase
    end

    // State and the memory of last cycle's write level change together.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q   <= apc_pkg::APC_ST_READY;
            wr_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q   <= state_d;
            wr_prev_q <= !wr_active;
        end
    end

    // The buffer is written only from an idle port, so a write while busy is dropped.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            buffer_q <= apc_pkg::BYTE_RESET;
        end
        else if (clk_en && load_byte)
        begin
            buffer_q <= pins.data;
        end
    end

    // The counter and the done pulse share one block because both follow the transfer state.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q   <= apc_pkg::CNT_RESET;
            valid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_q   <= cnt_d;
            valid_q <= xfer_end;
        end
    end

    // The status word is combinational, so a poll sees ready in the cycle that it returns.
    wire [7:0] status_word = {is_ready, apc_pkg::STATUS_LOW_BITS};
    wire [7:0] status_oe   = rd_active ? 8'hFF : 8'h00;
    assign drive = '{data_out: rd_active ? status_word : user_out,
                     data_oe:  config_mode ? status_oe : user_oe};

    // During configuration the control pins read all ones, so all but the high-active select look idle to the fabric.
    assign config_byte_bus_out = drive.data_out;
    assign config_byte_bus_oe  = drive.data_oe;
    assign ready_busy_flag     = is_ready;
    assign cfg_byte            = buffer_q;
    assign cfg_byte_valid      = valid_q;
    assign next_select_high    = chain_mode && !is_ready;
    assign user_ctrl_pins      = config_mode ? 4'hF : {pins.sel_n, pins.sel, pins.wr_n, pins.rd_n};
    assign user_data_pins      = config_mode ? 8'h00 : pins.data;

    // The checks watch synchronised pins, so they describe what the port decides,
    // two edges after the host moves a pin.
    busy_after_write_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && wr_fall && is_ready |=> !ready_busy_flag)
        else $error("Write did not report busy.");

    capture_byte_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && wr_fall && is_ready |=> cfg_byte == $past(pins.data))
        else $error("Byte not captured.");

    status_top_bit_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_active |-> config_byte_bus_oe[7] && config_byte_bus_out[7] == is_ready)
        else $error("Status bit wrong.");

    status_low_high_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_active |-> config_byte_bus_out[6:0] == 7'h7F && config_byte_bus_oe[6:0] == 7'h7F)
        else $error("Low status lines not high.");

    write_overrides_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        config_mode && !pins.wr_n && !pins.rd_n |-> config_byte_bus_oe == 8'h00)
        else $error("Status driven during write.");

    select_needed_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !chain_mode && (pins.sel_n || !pins.sel) |=> $stable(cfg_byte))
        else $error("Byte taken without both selects.");

    chain_enable_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chain_mode && !pins.sel |=> $stable(cfg_byte))
        else $error("Chain accepted without enable.");

    user_release_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !config_mode |-> config_byte_bus_oe == user_oe && user_ctrl_pins[0] == pins.rd_n)
        else $error("Pins not released.");

    chain_status_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        chain_mode |-> next_select_high == !ready_busy_flag)
        else $error("Chain status wrong.");

    ready_returns_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && in_xfer && cnt_done && core_ready |=> ready_busy_flag)
        else $error("Ready not restored.");

    single_pulse_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && cfg_byte_valid |=> !cfg_byte_valid)
        else $error("Done pulse longer than one cycle.");

    busy_holds_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        clk_en && !is_ready && !cnt_done |=> !ready_busy_flag)
        else $error("Busy ended before the transfer.");

    write_seen_c:  cover property (@(posedge clk) disable iff (sys_rst) wr_fall && is_ready);
    status_read_c: cover property (@(posedge clk) disable iff (sys_rst) rd_active && !is_ready);
    both_low_c:    cover property (@(posedge clk) disable iff (sys_rst) wr_active && !pins.rd_n);
    byte_done_c:   cover property (@(posedge clk) disable iff (sys_rst) cfg_byte_valid);
    chain_write_c: cover property (@(posedge clk) disable iff (sys_rst) chain_mode && load_byte);

endmodule // apc_port

// ===== apc_pkg.sv
// Purpose: Shared constants and types for the asynchronous peripheral configuration port.
// Assumes: One 20 MHz clock; pin inputs are synchronised inside the port.
// Notes:   The transfer time of the internal byte buffer is a plain default.
package apc_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned XFER_TIME_NS    = 400;
    localparam int unsigned XFER_CYCLES     = (XFER_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0]  XFER_CNT_MAX    = 8'(XFER_CYCLES);
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [7:0]  CNT_RESET       = 8'h00;
    localparam logic [6:0]  STATUS_LOW_BITS = 7'h7F;
    localparam int unsigned SYNC_STAGES     = 2;

    typedef enum logic [1:0]
    {
        APC_MODE_PERIPH = 2'b00,
        APC_MODE_CHAIN  = 2'b01,
        APC_MODE_USER   = 2'b10
    } apc_mode_t;

    typedef enum logic [1:0]
    {
        APC_ST_READY = 2'b00,
        APC_ST_WAIT  = 2'b01,
        APC_ST_XFER  = 2'b10
    } apc_state_t;

    // Pin group after synchronisation.
    typedef struct packed
    {
        logic       sel_n;
        logic       sel;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] data;
    } apc_pins_t;

    // Two-signal view of the eight data pins.
    typedef struct packed
    {
        logic [7:0] data_out;
        logic [7:0] data_oe;
    } apc_bus_drive_t;

endpackage

// ===== apc_sync.sv
// Purpose: Two-stage synchroniser for the asynchronous pin group.
// Assumes: Inputs arrive from outside the clock domain.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module apc_sync
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    input  wire apc_pkg::apc_pins_t pins_raw,
    output apc_pkg::apc_pins_t      pins_sync
);

    // Strobes and selects reset to their inactive levels.
    localparam apc_pkg::apc_pins_t IDLE_PINS = '{sel_n: 1'b1, sel: 1'b0, wr_n: 1'b1,
                                                rd_n: 1'b1, data: 8'h00};

    apc_pkg::apc_pins_t stage1_q;
    apc_pkg::apc_pins_t stage2_q;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1_q <= IDLE_PINS;
            stage2_q <= IDLE_PINS;
        end
        else if (clk_en)
        begin
            stage1_q <= pins_raw;
            stage2_q <= stage1_q;
        end
    end

    assign pins_sync = stage2_q;

endmodule // apc_sync

// ===== apc_host.sv
// Purpose: Host processor model driving the select, strobe and data pins.
// Assumes: Pins change 2 ns after a rising edge and are held by the caller.
// Notes:   Released data lines float to the pull-up level in the bench.
`timescale 1ns/1ps
module apc_host
(
    input  wire logic       clk,
    output logic [3:0]      ctl,
    output logic [7:0]      data_drv,
    output logic            data_en
);
    // The ctl bits are select_low_active_n, select_high_active, write_strobe_n, read_strobe_n.
    initial
    begin
        ctl      = 4'hB;
        data_drv = 8'h00;
        data_en  = 1'b0;
    end
    // Both strobes low only ever comes from a caller that asks for it.
    task automatic start(input logic [3:0] c, input logic [7:0] d);
        @(posedge clk);
        #2;
        ctl      = c;
        data_drv = d;
        data_en  = ~c[1];
    endtask
    task automatic stop();
        @(posedge clk);
        #2;
        ctl     = 4'hB;
        data_en = 1'b0;
    endtask
endmodule // apc_host

// ===== apc_port_tb.sv
// Purpose: Self-checking bench for the peripheral configuration port.
// Assumes: A host model drives the pins; the core accepts the buffer except during the stall test.
// Notes:   Undriven data pins read high, as the pin pull-ups make them.
`timescale 1ns/1ps
module apc_port_tb;
    logic clk, sys_rst, data_en, valid, next_sel, flag, core_ready;
    logic [3:0] ctl, user_ctrl;
    logic [7:0] data_drv, bus_out, bus_oe, user_out, user_oe, user_data, cfg_byte, pin_bus;
    logic [9:0] s;
    apc_pkg::apc_mode_t mode;
    int n_mismatch, cmp_count, n_valid, v, i;
    assign pin_bus = (bus_oe & bus_out) | (~bus_oe & (data_en ? data_drv : 8'hFF));
    apc_host u_apc_host (.clk(clk), .ctl(ctl), .data_drv(data_drv), .data_en(data_en));
    apc_port u_apc_port (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .mode(mode),
        .select_low_active_n(ctl[3]), .select_high_active(ctl[2]), .write_strobe_n(ctl[1]),
        .read_strobe_n(ctl[0]), .config_byte_bus_in(pin_bus), .config_byte_bus_out(bus_out),
        .config_byte_bus_oe(bus_oe), .user_out(user_out), .user_oe(user_oe),
        .user_ctrl_pins(user_ctrl), .user_data_pins(user_data), .core_ready(core_ready),
        .cfg_byte(cfg_byte), .cfg_byte_valid(valid), .next_select_high(next_sel),
        .ready_busy_flag(flag));
    always @(posedge clk) if (valid === 1'b1) n_valid++;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A poll that runs out of its limit is caught by the flag check that follows it.
    task automatic wait_ready();
        for (i = 0; i < 40 && flag !== 1'b1; i++)
        begin
            @(posedge clk);
            #2;
        end
        check({7'h00, flag}, 8'h01);
    endtask
    // Snapshot s = {flag, next_sel, bus_oe} while the write strobe is held.
    task automatic wr(input logic [3:0] c, input logic [7:0] d);
        v = n_valid;
        u_apc_host.start(c, d);
        repeat (4) @(posedge clk);
        #2 s = {flag, next_sel, bus_oe};
        u_apc_host.stop();
        wait_ready();
        repeat (2) @(posedge clk);
    endtask
    task automatic t_write();
        wr(4'h5, 8'hA5);
        check({7'h00, s[9]}, 8'h00);
        check({7'h00, s[8]}, 8'h00);
        check(cfg_byte, 8'hA5);
        check(8'(n_valid - v), 8'h01);
        check(8'(i >= apc_pkg::XFER_CYCLES), 8'h01);
    endtask
    task automatic t_status();
        u_apc_host.start(4'h5, 8'h3C);
        repeat (4) @(posedge clk);
        u_apc_host.start(4'h6, 8'h00);
        repeat (3) @(posedge clk);
        #2 check(pin_bus, 8'h7F);
        check(bus_oe, 8'hFF);
        wait_ready();
        repeat (3) @(posedge clk);
        #2 check(pin_bus, 8'hFF);
        u_apc_host.stop();
        repeat (4) @(posedge clk);
        check(bus_oe, 8'h00);
        check(cfg_byte, 8'h3C);
    endtask
    task automatic t_unsel();
        logic [3:0] tbl [3] = '{4'hD, 4'h1, 4'h9};
        foreach (tbl[k])
        begin
            wr(tbl[k], 8'h11);
            check({7'h00, s[9]}, 8'h01);
            check(cfg_byte, 8'h3C);
        end
    endtask
    task automatic t_both();
        wr(4'h4, 8'h5A);
        check(s[7:0], 8'h00);
        check(cfg_byte, 8'h5A);
    endtask
    task automatic t_chain();
        @(posedge clk) #2 mode = apc_pkg::APC_MODE_CHAIN;
        wr(4'h1, 8'hC3);
        check(cfg_byte, 8'h5A);
        wr(4'hD, 8'hC3);
        check(cfg_byte, 8'hC3);
        check({7'h00, s[8]}, 8'h01);
    endtask
    task automatic t_user();
        @(posedge clk) #2 mode = apc_pkg::APC_MODE_USER;
        u_apc_host.start(4'h4, 8'h3C);
        repeat (4) @(posedge clk);
        #2 check({4'h0, user_ctrl}, 8'h04);
        check(bus_oe, 8'h0F);
        check(user_data, 8'h36);
        u_apc_host.stop();
        repeat (4) @(posedge clk);
        check(cfg_byte, 8'hC3);
    endtask
    // The core holds off the buffer: busy must outlast the counter until it accepts.
    task automatic t_stall();
        @(posedge clk);
        #2;
        mode       = apc_pkg::APC_MODE_PERIPH;
        core_ready = 1'b0;
        v          = n_valid;
        u_apc_host.start(4'h5, 8'h77);
        repeat (4) @(posedge clk);
        u_apc_host.stop();
        repeat (20) @(posedge clk);
        #2 check({7'h00, flag}, 8'h00);
        check(8'(n_valid - v), 8'h00);
        core_ready = 1'b1;
        wait_ready();
        repeat (2) @(posedge clk);
        check(8'(n_valid - v), 8'h01);
        check(cfg_byte, 8'h77);
    endtask
    task automatic end_of_test();
        $display("cmp_count=%0d n_mismatch=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        $display("mismatch t=%0t watchdog expired", $time);
        end_of_test();
    end
    initial
    begin
        sys_rst    = 1'b1;
        core_ready = 1'b1;
        mode       = apc_pkg::APC_MODE_PERIPH;
        user_out   = 8'h96;
        user_oe    = 8'h0F;
        repeat (4) @(posedge clk);
        #2 sys_rst = 1'b0;
        check({flag, bus_oe[6:0]}, 8'h80);
        check(cfg_byte, 8'h00);
        t_write();
        t_status();
        t_unsel();
        t_both();
        t_chain();
        t_user();
        t_stall();
        end_of_test();
    end
endmodule // apc_port_tb
